// *** verilog/crc_fifo_consts.vh ***
// Constants for the CRC data-input block: register map, field layout,
// reset values and FIFO sizes.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef CRC_FIFO_CONSTS_VH
`define CRC_FIFO_CONSTS_VH

// ============================================================
// Bus geometry
`define ADDR_W 3
`define DATA_W 16

// ============================================================
// Register offsets (word addresses)
`define OFS_CONTROL 3'h0
`define OFS_WRITE_DATA 3'h1
`define OFS_INT_STATUS 3'h2
`define OFS_INT_CLEAR 3'h3
`define OFS_INT_ENABLE 3'h4

// ============================================================
// Control register field positions
`define POLY_LENGTH_LSB 0
`define POLY_LENGTH_MSB 3
`define GO_BIT 4
`define EMPTY_BIT 6
`define FULL_BIT 7
`define COUNT_LSB 8
`define COUNT_MSB 12

// ============================================================
// Interrupt event bits
`define EV_W 1
`define EV_DRAIN 0

// ============================================================
// FIFO sizing and reset values
`define POLY_LENGTH_W 4
`define COUNT_W 5
`define POLY_LENGTH_WIDE 4'h7
`define DEPTH_WIDE 5'h08
`define DEPTH_NARROW 5'h10
`define POLY_LENGTH_RST 4'h0
`define COUNT_ONE 5'h01
`define COUNT_ZERO 5'h00

`endif

// *** verilog/crc_elem_fifo.v ***
// Element store for the CRC input queue: array, write and read pointers.
// Assumes the owner keeps the word count and never pops when empty.
`timescale 1ns/1ps
module crc_elem_fifo #(
  parameter WIDTH = 16,
  parameter PTR_W = 4
) (
  // Clock and reset
  input wire clock,
  input wire rst_b,
  // Queue control
  input wire push,
  input wire [WIDTH-1:0] wdata,
  input wire pop,
  input wire flush,
  // Oldest element
  output wire [WIDTH-1:0] head
);

  // ============================================================
  // Storage
  reg [WIDTH-1:0] mem [0:(1<<PTR_W)-1]; // Element array
  reg [PTR_W-1:0] wr_ptr_r; // Next slot to fill
  reg [PTR_W-1:0] rd_ptr_r; // Oldest slot

  assign head = mem[rd_ptr_r];

  // Array write, no reset needed on data
  always @(posedge clock) begin
    if (push && !flush) begin
      mem[wr_ptr_r] <= wdata;
    end
  end

  // Pointer update; flush drops everything queued
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_r <= {PTR_W{1'b0}};
      rd_ptr_r <= {PTR_W{1'b0}};
    end else if (flush) begin
      wr_ptr_r <= {PTR_W{1'b0}};
      rd_ptr_r <= {PTR_W{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

endmodule // crc_elem_fifo

// *** verilog/crc_bit_shifter.v ***
// Serial shifter: sends the head element MSb first, up to two bits a cycle.
// Assumes the head element stays put until elem_done has been seen.
`timescale 1ns/1ps
module crc_bit_shifter #(
  parameter WIDTH = 16,
  parameter IDX_W = 4
) (
  // Clock and reset
  input wire clock,
  input wire rst_b,
  // Control
  input wire run,
  input wire restart,
  input wire [IDX_W-1:0] msb_idx,
  input wire [WIDTH-1:0] head,
  // Element finished this cycle
  output wire elem_done,
  // Bits to the CRC engine
  output reg bits_valid_r,
  output reg [1:0] bits_r,
  output reg two_bits_r
);

  // ============================================================
  // Position tracking
  reg busy_r; // Mid-element
  reg [IDX_W-1:0] idx_r; // Next bit to send
  wire [IDX_W-1:0] cur; // Bit sent this cycle
  wire has_two; // A second bit remains

  assign cur = busy_r ? idx_r : msb_idx;
  assign has_two = (cur != {IDX_W{1'b0}});
  // Last one or two bits leave now
  assign elem_done = run && (cur <= {{(IDX_W-1){1'b0}}, 1'b1});

  // Shift step; pausing keeps idx_r so the element resumes in place
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy_r <= 1'b0;
      idx_r <= {IDX_W{1'b0}};
      bits_valid_r <= 1'b0;
      bits_r <= 2'h0;
      two_bits_r <= 1'b0;
    end else if (restart) begin
      busy_r <= 1'b0;
      bits_valid_r <= 1'b0;
    end else if (run) begin
      bits_valid_r <= 1'b1;
      bits_r <= {head[cur], has_two ? head[cur-1'b1] : 1'b0};
      two_bits_r <= has_two;
      busy_r <= !elem_done;
      idx_r <= cur - 2'h2;
    end else begin
      bits_valid_r <= 1'b0;
    end
  end

endmodule // crc_bit_shifter

// *** verilog/crc_fifo_shift_interface.v ***
// Data-input side of a CRC generator: register port, element queue,
// valid-word count, full and empty flags and the drain interrupt.
// Assumes one 200 MHz clock, software on the plain register port and a
// CRC engine that takes up to two bits a cycle and returns its result.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "crc_fifo_consts.vh"

// How it works
// - Queue depth eight if poly_length above seven
// - Element holds poly_length+1 low bits
// - Element write into a non-full queue bumps count unless an element shifts out that cycle
// - Shift while go and count nonzero
// - Up to two bits per cycle per element
// - Full at depth, empty at zero
// - Write when full rolls count to zero
// - Interrupt on count one to zero
module crc_fifo_shift_interface #(
  parameter PTR_W = 4
) (
  // Clock and reset
  input wire CLOCK,
  input wire RST_B,
  // Register port
  input wire [`ADDR_W-1:0] ADDR,
  input wire [`DATA_W-1:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [`DATA_W-1:0] RDATA,
  // CRC engine
  input wire [`DATA_W-1:0] CRC_RESULT,
  output wire SHIFT_VALID,
  output wire [1:0] SHIFT_BITS,
  output wire SHIFT_TWO,
  // Interrupt
  output reg IRQ
);

  // ============================================================
  // Reset release
  reg rst_meta_r; // First stage, read only by second
  reg rst_sync_r; // Synchronised active-low reset
  wire rst_b;

  // Assert at once, release after two edges
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_b = rst_sync_r;

  // ============================================================
  // Address decode
  wire sel_control; // Control register
  wire sel_data; // Write data / result
  wire sel_status; // Interrupt status
  wire sel_clear; // Interrupt clear
  wire sel_enable; // Interrupt enable

  assign sel_control = (ADDR == `OFS_CONTROL);
  assign sel_data = (ADDR == `OFS_WRITE_DATA);
  assign sel_status = (ADDR == `OFS_INT_STATUS);
  assign sel_clear = (ADDR == `OFS_INT_CLEAR);
  assign sel_enable = (ADDR == `OFS_INT_ENABLE);

  // ============================================================
  // Control state
  reg [`POLY_LENGTH_W-1:0] poly_length_r; // Element width minus one
  reg shift_go_r; // Shifter may run
  reg [`COUNT_W-1:0] valid_word_count_r; // Queued elements
  reg [`COUNT_W-1:0] valid_word_count_nxt;
  reg fifo_full_flag_r; // Count at depth
  reg fifo_empty_flag_r; // Count at zero
  reg [`EV_W-1:0] int_status_r; // Sticky events
  reg [`EV_W-1:0] int_status_nxt;
  reg [`EV_W-1:0] int_enable_r; // Event mask

  // Depth follows element width
  function [`COUNT_W-1:0] depth_of;
    input [`POLY_LENGTH_W-1:0] poly_length;
    begin
      if (poly_length > `POLY_LENGTH_WIDE) begin
        depth_of = `DEPTH_WIDE;
      end else begin
        depth_of = `DEPTH_NARROW;
      end
    end
  endfunction

  wire [`COUNT_W-1:0] depth; // Current queue depth
  wire data_wr; // Element written
  wire overflow; // Write into full queue
  wire push; // Element accepted
  wire run; // Shifter allowed this cycle
  wire elem_done; // Element fully shifted
  wire drain_event; // Count went one to zero
  wire [`DATA_W-1:0] head; // Oldest element

  assign depth = depth_of(poly_length_r);
  // Whole element arrives in one 16-bit write, so its MSb is always written
  assign data_wr = WR && sel_data;
  assign overflow = data_wr && fifo_full_flag_r;
  assign push = data_wr && !fifo_full_flag_r;
  assign run = shift_go_r && (valid_word_count_r != `COUNT_ZERO);

  // ============================================================
  // Control register writes
  always @(posedge CLOCK or negedge rst_b) begin
    if (!rst_b) begin
      poly_length_r <= `POLY_LENGTH_RST;
      shift_go_r <= 1'b0;
    end else if (WR && sel_control) begin
      poly_length_r <= WDATA[`POLY_LENGTH_MSB:`POLY_LENGTH_LSB];
      shift_go_r <= WDATA[`GO_BIT];
    end
  end

  // ============================================================
  // Valid-word count
  // Push and finished element in one cycle cancel out
  always @* begin
    valid_word_count_nxt = valid_word_count_r;
    if (overflow) begin
      // Roll over: queue looks empty, not a drain
      valid_word_count_nxt = `COUNT_ZERO;
    end else if (push && !elem_done) begin
      valid_word_count_nxt = valid_word_count_r + `COUNT_ONE;
    end else if (elem_done && !push) begin
      valid_word_count_nxt = valid_word_count_r - `COUNT_ONE;
    end
  end

  // Only a shift-out decrement can reach zero from one
  assign drain_event = elem_done && !push && !overflow &&
                       (valid_word_count_r == `COUNT_ONE);

  // Count and flags registered together so they always agree
  always @(posedge CLOCK or negedge rst_b) begin
    if (!rst_b) begin
      valid_word_count_r <= `COUNT_ZERO;
      fifo_full_flag_r <= 1'b0;
      fifo_empty_flag_r <= 1'b1;
    end else begin
      valid_word_count_r <= valid_word_count_nxt;
      fifo_full_flag_r <= (valid_word_count_nxt == depth);
      fifo_empty_flag_r <= (valid_word_count_nxt == `COUNT_ZERO);
    end
  end

  // ============================================================
  // Interrupt status, enable and output
  // A new event wins over a clear in the same cycle
  always @* begin
    int_status_nxt = int_status_r;
    if (WR && sel_clear) begin
      int_status_nxt = int_status_r & ~WDATA[`EV_W-1:0];
    end
    if (drain_event) begin
      int_status_nxt[`EV_DRAIN] = 1'b1;
    end
  end

  // Status, mask and the registered level interrupt
  always @(posedge CLOCK or negedge rst_b) begin
    if (!rst_b) begin
      int_status_r <= {`EV_W{1'b0}};
      int_enable_r <= {`EV_W{1'b0}};
      IRQ <= 1'b0;
    end else begin
      int_status_r <= int_status_nxt;
      if (WR && sel_enable) begin
        int_enable_r <= WDATA[`EV_W-1:0];
      end
      IRQ <= |(int_status_nxt & int_enable_r);
    end
  end

  // ============================================================
  // Read data, one cycle after the strobe and only then
  always @(posedge CLOCK or negedge rst_b) begin
    if (!rst_b) begin
      RDATA <= {`DATA_W{1'b0}};
    end else if (!RD) begin
      RDATA <= {`DATA_W{1'b0}};
    end else if (sel_control) begin
      RDATA <= {`DATA_W{1'b0}};
      RDATA[`POLY_LENGTH_MSB:`POLY_LENGTH_LSB] <= poly_length_r;
      RDATA[`GO_BIT] <= shift_go_r;
      RDATA[`EMPTY_BIT] <= fifo_empty_flag_r;
      RDATA[`FULL_BIT] <= fifo_full_flag_r;
      RDATA[`COUNT_MSB:`COUNT_LSB] <= valid_word_count_r;
    end else if (sel_data) begin
      // Engine result; meaningful once the queue has drained
      RDATA <= CRC_RESULT;
    end else if (sel_status) begin
      RDATA <= {{(`DATA_W-`EV_W){1'b0}}, int_status_r};
    end else if (sel_enable) begin
      RDATA <= {{(`DATA_W-`EV_W){1'b0}}, int_enable_r};
    end else begin
      // Unmapped and write-only offsets read as zero
      RDATA <= {`DATA_W{1'b0}};
    end
  end

  // ============================================================
  // Element queue
  // Always sixteen slots; the wider-element depth just stops the count earlier
  crc_elem_fifo #(
    .WIDTH(`DATA_W),
    .PTR_W(PTR_W)
  ) u_queue (
    .clock(CLOCK),
    .rst_b(rst_b),
    .push(push),
    .wdata(WDATA),
    .pop(elem_done),
    .flush(overflow),
    .head(head)
  );

  // ============================================================
  // Serial shifter
  // Upper bits above poly_length are never looked at
  crc_bit_shifter #(
    .WIDTH(`DATA_W),
    .IDX_W(`POLY_LENGTH_W)
  ) u_shift (
    .clock(CLOCK),
    .rst_b(rst_b),
    .run(run),
    .restart(overflow),
    .msb_idx(poly_length_r),
    .head(head),
    .elem_done(elem_done),
    .bits_valid_r(SHIFT_VALID),
    .bits_r(SHIFT_BITS),
    .two_bits_r(SHIFT_TWO)
  );

endmodule // crc_fifo_shift_interface

// *** testbench/crc_fifo_checker.sv ***
// Checker for the CRC data-input block: flags, shift link and interrupt.
// Assumes it sees only the top ports; it mirrors the written control bits.
`timescale 1ns/1ps
module crc_fifo_checker #(
  parameter PTR_W = 4
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // Register port
  input wire logic [2:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  // CRC engine and interrupt
  input wire logic [15:0] CRC_RESULT,
  input wire logic SHIFT_VALID,
  input wire logic [1:0] SHIFT_BITS,
  input wire logic SHIFT_TWO,
  input wire logic IRQ
);
  // ==========
  // Mirrors
  logic go_r; // Shift enable copy
  logic odd_r; // Low bit of poly_length copy
  logic en_r; // Drain enable copy
  wire ctl_wr = WR && (ADDR == 3'h0);
  wire en_wr = WR && (ADDR == 3'h4);
  wire clr_wr = WR && (ADDR == 3'h3) && WDATA[0];
  wire ctl_rd = RD && (ADDR == 3'h0);
  wire [4:0] cnt = RDATA[12:8]; // Count as read back
  wire [4:0] dep = (RDATA[3:0] > 4'h7) ? 5'h08 : 5'h10; // Depth for read length
  // Mirrors follow writes only, never the design
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      go_r <= 1'b0;
      odd_r <= 1'b0;
      en_r <= 1'b0;
    end else begin
      if (ctl_wr) begin
        go_r <= WDATA[4];
        odd_r <= WDATA[0];
      end
      if (en_wr) begin
        en_r <= WDATA[0];
      end
    end
  end
  // ==========
  // Properties
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  AST_SHIFT_GO: assert property (SHIFT_VALID |-> $past(go_r))
    else $error("step without go");
  AST_TWO_BITS: assert property (SHIFT_VALID && $past(odd_r) |-> SHIFT_TWO)
    else $error("single bit on even width");
  AST_EMPTY: assert property (ctl_rd |=> RDATA[6] == (cnt == 5'h00))
    else $error("empty flag wrong");
  AST_FULL: assert property (ctl_rd |=> RDATA[7] == (cnt == dep))
    else $error("full flag wrong");
  AST_COUNT_LIMIT: assert property (ctl_rd |=> cnt <= dep)
    else $error("count above depth");
  AST_GO_BACK: assert property (ctl_rd |=> RDATA[4] == $past(go_r))
    else $error("go readback wrong");
  AST_IRQ_CAUSE: assert property ($rose(IRQ) |-> SHIFT_VALID || $past(en_wr, 2))
    else $error("interrupt without drain");
  AST_IRQ_STICKY: assert property (IRQ && en_r && !en_wr && !clr_wr |=> IRQ)
    else $error("interrupt dropped");
  AST_IRQ_MASK: assert property (IRQ |-> en_r || $past(en_r))
    else $error("interrupt while masked");
  // Main scenarios
  cover property (SHIFT_VALID && !SHIFT_TWO);
  cover property ($rose(IRQ));
  cover property (ctl_rd ##1 RDATA[7]);
endmodule // crc_fifo_checker

bind crc_fifo_shift_interface crc_fifo_checker #(.PTR_W(PTR_W)) chk_i (
  .CLOCK(CLOCK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .CRC_RESULT(CRC_RESULT), .SHIFT_VALID(SHIFT_VALID),
  .SHIFT_BITS(SHIFT_BITS), .SHIFT_TWO(SHIFT_TWO), .IRQ(IRQ));

// *** testbench/crc_engine_model.sv ***
// Far-side model: collects shifted bits, MSb first, as its result word.
// Assumes one clock; the result is a plain bit stream, not a real CRC.
`timescale 1ns/1ps
module crc_engine_model (
  // Clock and reset
  input wire clock,
  input wire rst_b,
  // Bench control
  input wire clr,
  // Shift link
  input wire valid,
  input wire [1:0] bits,
  input wire two,
  // Result and step tally
  output reg [15:0] result,
  output reg [7:0] steps
);
  // ==========
  // Stream collector; older bits fall off the top
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      result <= 16'h0000;
      steps <= 8'h00;
    end else if (clr) begin
      result <= 16'h0000;
      steps <= 8'h00;
    end else if (valid) begin
      result <= two ? {result[13:0], bits} : {result[14:0], bits[1]};
      steps <= steps + 8'h01;
    end
  end
endmodule // crc_engine_model

// *** testbench/tb_top.sv ***
// Self-checking bench for the CRC data-input block.
// Assumes the checker binds itself and the engine model answers each step.
`timescale 1ns/1ps
module tb_top;
  // ==========
  // Signals
  reg CLOCK = 1'b0;
  reg RST_B = 1'b0;
  reg [2:0] ADDR = 3'h0;
  reg [15:0] WDATA = 16'h0000;
  reg WR = 1'b0;
  reg RD = 1'b0;
  reg model_clr = 1'b0;
  wire [15:0] RDATA, CRC_RESULT;
  wire SHIFT_VALID, SHIFT_TWO, IRQ;
  wire [1:0] SHIFT_BITS;
  wire [7:0] steps;
  integer err_total = 0;
  integer tests_run = 0;
  integer i, j, k, n, w, dep;
  reg [31:0] seed = 32'h10;
  reg [31:0] acc;
  reg [15:0] q, d;
  reg [3:0] pl;
  reg done;
  always #2.5 CLOCK = ~CLOCK;
  crc_fifo_shift_interface uut (.CLOCK(CLOCK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .CRC_RESULT(CRC_RESULT), .SHIFT_VALID(SHIFT_VALID),
    .SHIFT_BITS(SHIFT_BITS), .SHIFT_TWO(SHIFT_TWO), .IRQ(IRQ));
  crc_engine_model eng (.clock(CLOCK), .rst_b(RST_B), .clr(model_clr), .valid(SHIFT_VALID),
    .bits(SHIFT_BITS), .two(SHIFT_TWO), .result(CRC_RESULT), .steps(steps));
  // ==========
  // Helpers
  function automatic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    xs = seed;
  endfunction
  // Control word as software should see it
  function automatic [15:0] ctl_exp(input [4:0] c, input g, input [3:0] p);
    reg [4:0] dp;
    dp = (p > 4'h7) ? 5'h08 : 5'h10;
    ctl_exp = {3'h0, c, c == dp, c == 5'h00, 1'b0, g, p};
  endfunction
  task tick;
    begin
      @(posedge CLOCK);
      #1;
    end
  endtask
  task wr(input [2:0] a, input [15:0] v);
    begin
      @(posedge CLOCK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge CLOCK);
      WR <= 1'b0;
    end
  endtask
  // Data stand only in the cycle after the strobe
  task rd(input [2:0] a, output [15:0] v);
    begin
      @(posedge CLOCK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLOCK);
      RD <= 1'b0;
      #1;
      v = RDATA;
    end
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Poll until the queue reports empty; running out of polls fails the run
  task wait_empty;
    begin
      done = 1'b0;
      for (k = 0; k < 300 && !done; k = k + 1) begin
        rd(3'h0, q);
        done = q[6];
      end
      if (!done) begin
        err_total = err_total + 1;
        results;
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (6) @(posedge CLOCK);
    RST_B <= 1'b1;
    repeat (3) @(posedge CLOCK);
    rd(3'h0, q);
    chk(q, ctl_exp(5'h00, 1'b0, 4'h0));
    for (k = 2; k < 8; k = k + 1) begin
      rd(k[2:0], q);
      chk(q, 16'h0000);
    end
    wr(3'h4, 16'h0001);
    rd(3'h4, q);
    chk(q, 16'h0001);
    $display("reset test done");
    // Drain runs, widths one and sixteen then random, pause on odd runs
    for (i = 0; i < 6; i = i + 1) begin
      d = xs();
      pl = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : d[3:0];
      w = pl + 1;
      n = 1 + xs() % 4;
      wr(3'h0, {11'h0, 1'b0, pl});
      @(posedge CLOCK);
      model_clr <= 1'b1;
      @(posedge CLOCK);
      model_clr <= 1'b0;
      acc = 0;
      for (j = 0; j < n; j = j + 1) begin
        d = xs();
        wr(3'h1, d);
        acc = (acc << w) | (d & ((32'h1 << w) - 1));
      end
      rd(3'h0, q);
      chk(q, ctl_exp(n[4:0], 1'b0, pl));
      wr(3'h0, {11'h0, 1'b1, pl});
      if (i % 2 == 1) begin
        wr(3'h0, {11'h0, 1'b0, pl});
        tick;
        tick;
        d = {8'h00, steps};
        repeat (4) tick;
        chk({8'h00, steps}, d);
        wr(3'h0, {11'h0, 1'b1, pl});
      end
      wait_empty;
      chk(q, ctl_exp(5'h00, 1'b1, pl));
      rd(3'h1, q);
      chk(q, acc[15:0]);
      d = n * ((w + 1) / 2);
      chk({8'h00, steps}, d);
      chk({15'h0, IRQ}, 16'h0001);
      wr(3'h4, 16'h0000);
      tick;
      chk({15'h0, IRQ}, 16'h0000);
      rd(3'h2, q);
      chk(q, 16'h0001);
      wr(3'h3, 16'h0001);
      rd(3'h2, q);
      chk(q, 16'h0000);
      wr(3'h4, 16'h0001);
      $display("drain test %0d done", i);
    end
    // Feed while shifting: a push may meet a shift-out in one cycle
    wr(3'h0, 16'h000F);
    @(posedge CLOCK);
    model_clr <= 1'b1;
    @(posedge CLOCK);
    model_clr <= 1'b0;
    wr(3'h1, xs());
    wr(3'h1, xs());
    wr(3'h0, 16'h001F);
    for (j = 0; j < 3; j = j + 1) begin
      d = xs();
      wr(3'h1, d);
    end
    wait_empty;
    chk(q, ctl_exp(5'h00, 1'b1, 4'hF));
    rd(3'h1, q);
    chk(q, d);
    chk({8'h00, steps}, 16'h0028);
    chk({15'h0, IRQ}, 16'h0001);
    wr(3'h3, 16'h0001);
    $display("stream test done");
    // Fill to depth, then one more rolls over
    for (i = 0; i < 2; i = i + 1) begin
      pl = i ? 4'h0 : 4'h8;
      dep = i ? 16 : 8;
      wr(3'h0, {11'h0, 1'b0, pl});
      for (j = 0; j < dep; j = j + 1) begin
        wr(3'h1, xs());
      end
      rd(3'h0, q);
      chk(q, ctl_exp(dep[4:0], 1'b0, pl));
      wr(3'h1, xs());
      rd(3'h0, q);
      chk(q, ctl_exp(5'h00, 1'b0, pl));
      rd(3'h2, q);
      chk({q[14:0], IRQ}, 16'h0000);
      $display("full test %0d done", i);
    end
    results;
  end
endmodule // tb_top
